//--- logic/differential_trip_logic.sv
// Top of the three-phase biased differential trip logic with its Wishbone
// register slave, per-phase trip timers and latched indicators.
// Assumes current samples and the operator button are synchronous.
//
// Summary of operation
// - Per phase differential and stabilizing quantities.
// - Differential is star side minus outgoing.
// - Fine pickup 5 to 42.5 percent, 2.5 steps.
// - Fine: above pickup and 10 percent bias.
// - Coarse: 100 percent pickup, 60 percent bias.
// - Detected transient selects coarse when detector fitted.
// - Up to rated current, trip after 100 ms.
// - Above rated current, trip after 40 ms.
// - Detector works on each phase separately.
// - Steep slope starts saturation, sign classifies.
// - One event per cycle DC, two AC.
// - Only external faults block the trip.
// - DC saturation blocks fully until released.
// - AC saturation blocks only saturated intervals.
// - Three phase fault indicators and trip indicator.
// - Coarse indicator lit while coarse is active.
// - Ready indicator with supply present.
// - Reset button clears latched indicators.
// - Quantities scaled to 1 A or 5 A.
// - Faulted phase is stored until acknowledged.
module differential_trip_logic
   import trip_pkg::*;
#(
   parameter int SLOW_CYC = trip_pkg::SLOW_DELAY_CYC,
   parameter int FAST_CYC = trip_pkg::FAST_DELAY_CYC,
   parameter int CYCLE_CYC = trip_pkg::POWER_CYCLE_CYC,
   parameter int INTERVAL_CYC = trip_pkg::SAT_INTERVAL_CYC
)(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [4:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Current samples, star side and outgoing side
   input wire logic i_sample_valid,
   input wire logic signed [15:0] i_star_a,
   input wire logic signed [15:0] i_out_a,
   input wire logic signed [15:0] i_star_b,
   input wire logic signed [15:0] i_out_b,
   input wire logic signed [15:0] i_star_c,
   input wire logic signed [15:0] i_out_c,
   // Operator panel
   input wire logic i_aux_supply_voltage,
   input wire logic i_reset_button,
   // Indicators and trip command
   output logic o_phase_a_fault_indicator,
   output logic o_phase_b_fault_indicator,
   output logic o_phase_c_fault_indicator,
   output logic o_trip,
   output logic o_coarse_indicator,
   output logic o_ready
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [5:0] ctrl;
      logic ack;
      logic [31:0] rdata;
      logic [2:0][TIMER_W-1:0] timer;
      logic [2:0] fault;
      logic trip;
      logic coarse;
      logic ready;
      logic [15:0] trips;
   } top_state_t;

   top_state_t st_q, st_d;

   logic [2:0] operate, over_rated, block, transient, external;
   logic signed [15:0] star [3];
   logic signed [15:0] outg [3];
   logic [2:0][16:0] diff_mag;
   logic [15:0] rated;
   logic sat_fitted;
   logic bus_req, bus_wr, ack_req, clear;
   logic [TIMER_W-1:0] limit;

   assign star[0] = i_star_a;
   assign star[1] = i_star_b;
   assign star[2] = i_star_c;
   assign outg[0] = i_out_a;
   assign outg[1] = i_out_b;
   assign outg[2] = i_out_c;

   assign sat_fitted = st_q.ctrl[CTRL_SAT_BIT];
   assign rated = st_q.ctrl[CTRL_RATED5_BIT] ? RATED_5A_COUNTS :
      RATED_1A_COUNTS;

   // ==========================================================
   // Per-phase measurement and saturation detection
   genvar ph;
   generate
      for (ph = 0; ph < 3; ph++) begin : g_phase
         logic signed [16:0] diff;

         phase_quantities u_quant (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_valid(i_sample_valid),
            .i_star(star[ph]),
            .i_out(outg[ph]),
            .i_step(st_q.ctrl[CTRL_STEP_LSB +: 4]),
            .i_coarse(st_q.coarse),
            .i_rated(rated),
            .o_diff(diff),
            .o_diff_mag(diff_mag[ph]),
            .o_operate(operate[ph]),
            .o_over_rated(over_rated[ph])
         );

         saturation_detector #(
            .CYCLE_CYC(CYCLE_CYC),
            .INTERVAL_CYC(INTERVAL_CYC)
         ) u_sat (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_enable(sat_fitted),
            .i_valid(i_sample_valid),
            .i_diff(diff),
            .o_transient(transient[ph]),
            .o_block(block[ph]),
            .o_external(external[ph])
         );
      end
   endgenerate

   // ==========================================================
   // Bus decode
   assign bus_req = i_wb_cyc && i_wb_stb && !st_q.ack;
   assign bus_wr = bus_req && i_wb_we;
   assign ack_req = bus_wr && (i_wb_adr == ADDR_CTRL) && i_wb_sel[1] &&
      i_wb_dat[CTRL_ACK_BIT];
   // Either the panel button or software may acknowledge.
   assign clear = i_reset_button || ack_req;

   // ==========================================================
   // Next state
   always_comb begin
      st_d = st_q;
      limit = '0;
      st_d.ack = bus_req;
      st_d.ready = i_aux_supply_voltage;

      // Coarse only when the detector is fitted and sees a transient.
      st_d.coarse = sat_fitted && (transient != 3'b000);

      if (clear) begin
         st_d.fault = 3'b000;
         st_d.trip = 1'b0;
      end

      for (int i = 0; i < 3; i++) begin
         limit = over_rated[i] ? TIMER_W'(FAST_CYC - 1) :
            TIMER_W'(SLOW_CYC - 1);
         if (operate[i] && !block[i]) begin
            if (st_q.timer[i] >= limit) begin
               // Trip wins over a simultaneous acknowledge.
               st_d.fault[i] = 1'b1;
               st_d.trip = 1'b1;
            end else begin
               st_d.timer[i] = st_q.timer[i] + 1'b1;
            end
         end else begin
            st_d.timer[i] = '0;
         end
      end

      // A clear and a new trip in one cycle leave the new trip counted.
      if (bus_wr && i_wb_adr == ADDR_TRIPS && i_wb_sel[0])
         st_d.trips = '0;
      if (st_d.trip && !st_q.trip && st_d.trips != 16'hffff)
         st_d.trips = st_d.trips + 1'b1;

      if (bus_wr && i_wb_adr == ADDR_CTRL && i_wb_sel[0])
         st_d.ctrl = i_wb_dat[5:0];

      st_d.rdata = '0;
      if (bus_req && !i_wb_we) begin
         unique case (i_wb_adr)
            ADDR_CTRL:
               st_d.rdata[5:0] = st_q.ctrl;
            ADDR_STATUS: begin
               st_d.rdata[STAT_FAULT_LSB +: 3] = st_q.fault;
               st_d.rdata[STAT_TRIP_BIT] = st_q.trip;
               st_d.rdata[STAT_COARSE_BIT] = st_q.coarse;
               st_d.rdata[STAT_READY_BIT] = st_q.ready;
               st_d.rdata[STAT_BLOCK_LSB +: 3] = block;
               st_d.rdata[STAT_TRANS_LSB +: 3] = transient;
            end
            ADDR_DIFF_A:
               st_d.rdata[16:0] = diff_mag[0];
            ADDR_DIFF_B:
               st_d.rdata[16:0] = diff_mag[1];
            ADDR_DIFF_C:
               st_d.rdata[16:0] = diff_mag[2];
            ADDR_TRIPS:
               st_d.rdata[15:0] = st_q.trips;
            ADDR_SAT:
               st_d.rdata[2:0] = external;
            default:
               st_d.rdata = '0;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   assign o_wb_ack = st_q.ack;
   assign o_wb_dat = st_q.rdata;
   assign o_phase_a_fault_indicator = st_q.fault[0];
   assign o_phase_b_fault_indicator = st_q.fault[1];
   assign o_phase_c_fault_indicator = st_q.fault[2];
   assign o_trip = st_q.trip;
   assign o_coarse_indicator = st_q.coarse;
   assign o_ready = st_q.ready;
endmodule

//--- logic/trip_pkg.sv
// Constants shared by the differential trip logic and its helper modules.
// Assumes a 20 MHz core clock and signed 16-bit current samples per side.
package trip_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SLOW_DELAY_MS = 100;
   localparam int FAST_DELAY_MS = 40;
   localparam int POWER_CYCLE_MS = 20;
   localparam int SAT_INTERVAL_MS = 5;
   localparam int SLOW_DELAY_CYC = CLK_HZ / 1000 * SLOW_DELAY_MS;
   localparam int FAST_DELAY_CYC = CLK_HZ / 1000 * FAST_DELAY_MS;
   localparam int POWER_CYCLE_CYC = CLK_HZ / 1000 * POWER_CYCLE_MS;
   localparam int SAT_INTERVAL_CYC = CLK_HZ / 1000 * SAT_INTERVAL_MS;
   localparam int TIMER_W = 24;

   // ==========================================================
   // Current scaling: sample counts that equal relay rated current, and the saturation slope limit.
   localparam logic [15:0] RATED_1A_COUNTS = 16'h0400;
   localparam logic [15:0] RATED_5A_COUNTS = 16'h1400;
   localparam logic [16:0] SAT_RATE_LIMIT = 17'h00200;

   // ==========================================================
   // Characteristics, in per mille or percent of rated, or percent of stabilizing
   localparam int FINE_BASE_PERMIL = 50;
   localparam int FINE_STEP_PERMIL = 25;
   localparam int FINE_BIAS_PCT = 10;
   localparam int COARSE_PICKUP_PCT = 100;
   localparam int COARSE_BIAS_PCT = 60;

   // ==========================================================
   // Register map, byte addresses on the Wishbone slave
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_DIFF_A = 5'h08;
   localparam logic [4:0] ADDR_DIFF_B = 5'h0c;
   localparam logic [4:0] ADDR_DIFF_C = 5'h10;
   localparam logic [4:0] ADDR_TRIPS = 5'h14;
   localparam logic [4:0] ADDR_SAT = 5'h18;

   // CTRL fields
   localparam int CTRL_STEP_LSB = 0;
   localparam int CTRL_SAT_BIT = 4;
   localparam int CTRL_RATED5_BIT = 5;
   localparam int CTRL_ACK_BIT = 8;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // STATUS fields
   localparam int STAT_FAULT_LSB = 0;
   localparam int STAT_TRIP_BIT = 3;
   localparam int STAT_COARSE_BIT = 4;
   localparam int STAT_READY_BIT = 5;
   localparam int STAT_BLOCK_LSB = 8;
   localparam int STAT_TRANS_LSB = 12;

endpackage

//--- logic/phase_quantities.sv
// Forms one phase's differential and stabilizing quantities and compares
// them against the fine or coarse characteristic.
// Assumes both side samples are signed, in the same scale, taken together.
module phase_quantities
   import trip_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Samples
   input wire logic i_valid,
   input wire logic signed [15:0] i_star,
   input wire logic signed [15:0] i_out,
   // Settings
   input wire logic [3:0] i_step,
   input wire logic i_coarse,
   input wire logic [15:0] i_rated,
   // Results
   output logic signed [16:0] o_diff,
   output logic [16:0] o_diff_mag,
   output logic o_operate,
   output logic o_over_rated
);
   typedef struct packed {
      logic signed [16:0] diff;
      logic [16:0] mag;
      logic [16:0] stab;
   } pq_state_t;

   pq_state_t st_q, st_d;
   logic [16:0] mag_star, mag_out;
   logic [31:0] lhs_pick, rhs_pick, lhs_bias, rhs_bias;

   always_comb begin
      st_d = st_q;
      mag_star = i_star[15] ? 17'(-32'(i_star)) : 17'(i_star);
      mag_out = i_out[15] ? 17'(-32'(i_out)) : 17'(i_out);
      if (i_valid) begin
         st_d.diff = 17'(i_star) - 17'(i_out);
         st_d.mag = st_d.diff[16] ? 17'(-st_d.diff) : 17'(st_d.diff);
         st_d.stab = 17'((18'(mag_star) + 18'(mag_out)) >> 1);
      end
      // Fixed-point compares avoid a divider: both sides are scaled up.
      if (i_coarse) begin
         lhs_pick = 32'(st_q.mag) * 32'(100);
         rhs_pick = 32'(i_rated) * 32'(COARSE_PICKUP_PCT);
         rhs_bias = 32'(st_q.stab) * 32'(COARSE_BIAS_PCT);
      end else begin
         lhs_pick = 32'(st_q.mag) * 32'(1000);
         rhs_pick = 32'(i_rated) *
            (32'(FINE_BASE_PERMIL) + 32'(FINE_STEP_PERMIL) * 32'(i_step));
         rhs_bias = 32'(st_q.stab) * 32'(FINE_BIAS_PCT);
      end
      lhs_bias = 32'(st_q.mag) * 32'(100);
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign o_diff = st_q.diff;
   assign o_diff_mag = st_q.mag;
   assign o_operate = (lhs_pick > rhs_pick) && (lhs_bias > rhs_bias);
   assign o_over_rated = st_q.mag > 17'(i_rated);
endmodule

//--- logic/saturation_detector.sv
// Watches one phase's differential current for steep slopes that mark
// transformer saturation, classifies it and decides when to block.
// Assumes a new differential value on each valid strobe.
module saturation_detector
   import trip_pkg::*;
#(
   parameter int CYCLE_CYC = POWER_CYCLE_CYC,
   parameter int INTERVAL_CYC = SAT_INTERVAL_CYC
)(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_enable,
   input wire logic i_valid,
   input wire logic signed [16:0] i_diff,
   output logic o_transient,
   output logic o_block,
   output logic o_external
);
   typedef struct packed {
      logic signed [16:0] prev;
      logic [TIMER_W-1:0] win;
      logic [TIMER_W-1:0] gap;
      logic [1:0] events;
      logic active;
      logic external;
      logic ac;
   } sat_state_t;

   sat_state_t st_q, st_d;
   logic signed [17:0] slope;
   logic [17:0] slope_mag;
   logic steep;

   always_comb begin
      st_d = st_q;
      slope = 18'(i_diff) - 18'(st_q.prev);
      slope_mag = slope[17] ? 18'(-slope) : 18'(slope);
      steep = i_enable && i_valid && (slope_mag > 18'(SAT_RATE_LIMIT));
      if (i_valid)
         st_d.prev = i_diff;
      if (st_q.gap != '0)
         st_d.gap = st_q.gap - 1'b1;
      if (st_q.win == TIMER_W'(CYCLE_CYC - 1)) begin
         st_d.win = '0;
         st_d.events = '0;
         // A quiet power cycle ends the transient.
         if (st_q.events == 2'd0) begin
            st_d.active = 1'b0;
            st_d.external = 1'b0;
            st_d.ac = 1'b0;
         end else begin
            st_d.ac = st_q.events >= 2'd2;
         end
      end else begin
         st_d.win = st_q.win + 1'b1;
      end
      if (steep) begin
         st_d.active = 1'b1;
         st_d.gap = TIMER_W'(INTERVAL_CYC);
         if (st_d.events != 2'd3)
            st_d.events = st_d.events + 1'b1;
         // Slope in the same sense as the current: internal fault.
         st_d.external = slope[17] != i_diff[16];
      end
      if (!i_enable)
         st_d = '{prev: st_d.prev, default: '0};
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign o_transient = st_q.active;
   assign o_external = st_q.external;
   assign o_block = st_q.active && st_q.external &&
      (!st_q.ac || (st_q.gap != '0));
endmodule

//--- bench/trip_checker_assertions.sv
// Port-level checker for the differential trip logic.
// Assumes it is bound into the top module and sees only its ports.
module trip_checker #(
   parameter int FAST_CYC = 8
)(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic i_aux_supply_voltage,
   input wire logic i_reset_button,
   input wire logic o_phase_a_fault_indicator,
   input wire logic o_phase_b_fault_indicator,
   input wire logic o_phase_c_fault_indicator,
   input wire logic o_trip,
   input wire logic o_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Cycles since reset
   // A trip needs the fast delay at least, so it can never rise sooner.
   logic [31:0] run_q;
   logic [31:0] run_d;
   always_comb run_d = run_q + 32'h1;
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) run_q <= 32'h0;
      else run_q <= run_d;
   end
   // ==========
   // Properties
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_ack;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   a_ack_answer: assert property (s_req |=> s_ack)
      else $error("bus request not answered in one pulse");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_read_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data outside ack");
   a_ready_follow: assert property (
      $past(i_nrst) |-> o_ready == $past(i_aux_supply_voltage))
      else $error("ready does not follow supply");
   a_reset_clear: assert property (disable iff (1'b0)
      !i_nrst |=> !o_trip && !o_ready && !o_wb_ack)
      else $error("reset left outputs set");
   a_trip_common: assert property (o_trip == (o_phase_a_fault_indicator
      || o_phase_b_fault_indicator || o_phase_c_fault_indicator))
      else $error("trip and phase faults disagree");
   a_fault_hold: assert property (o_phase_a_fault_indicator
      && !i_reset_button && !(i_wb_cyc && i_wb_stb && i_wb_we)
      |=> o_phase_a_fault_indicator)
      else $error("phase fault dropped without acknowledge");
   a_trip_early: assert property ($rose(o_trip) |-> run_q >= FAST_CYC)
      else $error("trip sooner than fast delay");
endmodule

bind differential_trip_logic trip_checker #(.FAST_CYC(FAST_CYC)) u_chk (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .i_aux_supply_voltage(i_aux_supply_voltage),
   .i_reset_button(i_reset_button),
   .o_phase_a_fault_indicator(o_phase_a_fault_indicator),
   .o_phase_b_fault_indicator(o_phase_b_fault_indicator),
   .o_phase_c_fault_indicator(o_phase_c_fault_indicator),
   .o_trip(o_trip), .o_ready(o_ready));

//--- bench/ct_channels.sv
// Behavioural current transformer channels and operator push-button.
// Assumes the bench sets wanted currents; one sample strobe per 4 cycles.
module ct_channels (
   input wire logic i_core_clk,
   input wire logic i_press,
   input wire logic signed [15:0] i_star [3],
   input wire logic signed [15:0] i_out [3],
   output logic o_valid,
   output logic signed [15:0] o_star [3],
   output logic signed [15:0] o_out [3],
   output logic o_button
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_q = 2'h0;
   logic [2:0] hold_q = 3'h0;
   logic valid_q = 1'b0;
   logic signed [15:0] star_q [3] = '{default: 16'sh0};
   logic signed [15:0] out_q [3] = '{default: 16'sh0};
   assign o_valid = valid_q;
   assign o_star = star_q;
   assign o_out = out_q;
   // Both sides change on the strobe edge only, so a set is never torn.
   always @(posedge i_core_clk) begin
      div_q <= div_q + 2'h1;
      valid_q <= (div_q == 2'h3);
      if (div_q == 2'h3) begin
         star_q <= i_star;
         out_q <= i_out;
      end
   end
   // A press is stretched to four cycles, as a hand holds a button.
   always @(posedge i_core_clk) begin
      if (i_press) hold_q <= 3'h4;
      else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
   end
   assign o_button = (hold_q != 3'h0);
endmodule

//--- bench/differential_trip_logic_tb.sv
// Self-checking bench for the differential trip logic with short timers.
// Assumes the package map and the channel model beside the block.
module differential_trip_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import trip_pkg::*;
   localparam int SLOW = 20;
   localparam int FAST = 8;
   localparam int CYC = 40;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dout;
   logic [31:0] rdat;
   logic ack;
   logic supply = 1'b1;
   logic press = 1'b0;
   logic signed [15:0] st [3] = '{default: 16'sh0};
   logic signed [15:0] ot [3] = '{default: 16'sh0};
   logic signed [15:0] ps [3];
   logic signed [15:0] po [3];
   logic valid;
   logic button;
   logic [2:0] flt;
   logic trip;
   logic coarse;
   logic ready;
   int error_cnt = 0;
   int checked = 0;

   initial forever #25 clk = ~clk;

   ct_channels u_ct (.i_core_clk(clk), .i_press(press), .i_star(st),
      .i_out(ot), .o_valid(valid), .o_star(ps), .o_out(po),
      .o_button(button));

   differential_trip_logic #(.SLOW_CYC(SLOW), .FAST_CYC(FAST),
      .CYCLE_CYC(CYC), .INTERVAL_CYC(10)) dut (
      .i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
      .o_wb_dat(dout), .o_wb_ack(ack), .i_sample_valid(valid),
      .i_star_a(ps[0]), .i_out_a(po[0]), .i_star_b(ps[1]),
      .i_out_b(po[1]), .i_star_c(ps[2]), .i_out_c(po[2]),
      .i_aux_supply_voltage(supply), .i_reset_button(button),
      .o_phase_a_fault_indicator(flt[0]),
      .o_phase_b_fault_indicator(flt[1]),
      .o_phase_c_fault_indicator(flt[2]), .o_trip(trip),
      .o_coarse_indicator(coarse), .o_ready(ready));

   // ==========
   // Shared tasks
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk);
      while (ack !== 1'b1);
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      chk("ack drop", 32'h0, 32'(ack));
   endtask
   task automatic set_i(input int p, input int s, input int o);
      st[p] <= 16'(s);
      ot[p] <= 16'(o);
   endtask
   task automatic ack_press();
      press <= 1'b1;
      tick(1);
      press <= 1'b0;
      tick(6);
   endtask
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========
   // Scenarios
   task automatic t_reset();
      chk("trip", 0, 32'(trip));
      chk("ready", 1, 32'(ready));
      wb(0, ADDR_CTRL, 0);
      chk("ctrl", 0, rdat);
      wb(1, 5'h1c, 32'hff);
      wb(0, 5'h1c, 0);
      chk("unmapped", 0, rdat);
      supply <= 1'b0;
      tick(2);
      chk("ready off", 0, 32'(ready));
      supply <= 1'b1;
      tick(2);
      $display("test reset done");
   endtask
   task automatic t_fine();
      wb(1, ADDR_CTRL, 32'hf);
      set_i(0, 435, 0);
      tick(SLOW + 10);
      chk("under pickup", 0, 32'(trip));
      set_i(0, 436, 0);
      tick(FAST + 4);
      chk("slow early", 0, 32'(trip));
      tick(SLOW - FAST + 6);
      chk("faults", 1, 32'(flt));
      wb(0, ADDR_STATUS, 0);
      chk("status", 32'h29, rdat);
      set_i(0, 0, 0);
      tick(10);
      chk("held", 1, 32'(flt));
      ack_press();
      chk("button", 0, 32'({trip, flt}));
      $display("test fine done");
   endtask
   task automatic t_fast();
      set_i(1, 1100, 0);
      tick(FAST + 9);
      chk("fast", 2, 32'(flt));
      chk("no detector", 0, 32'(coarse));
      set_i(1, 0, 0);
      tick(6);
      wb(1, ADDR_CTRL, 32'h120);
      chk("ack write", 0, 32'({trip, flt}));
      set_i(2, 1100, 0);
      tick(FAST + 4);
      chk("5 A early", 0, 32'(trip));
      tick(SLOW - FAST + 6);
      chk("5 A slow", 4, 32'(flt));
      set_i(2, 0, 0);
      tick(6);
      wb(1, ADDR_CTRL, 32'h100);
      $display("test fast done");
   endtask
   task automatic t_bias();
      set_i(0, 2000, 1900);
      set_i(1, -700, -700);
      tick(SLOW + 10);
      chk("biased", 0, 32'(trip));
      wb(0, ADDR_DIFF_A, 0);
      chk("diff a", 100, rdat);
      wb(0, ADDR_DIFF_B, 0);
      chk("diff b", 0, rdat);
      set_i(0, 2000, 1800);
      tick(SLOW + 10);
      chk("over bias", 1, 32'(flt));
      set_i(0, 0, 0);
      set_i(1, 0, 0);
      nrst <= 1'b0;
      tick(2);
      nrst <= 1'b1;
      tick(2);
      chk("mid reset", 0, 32'({trip, flt}));
      $display("test bias done");
   endtask
   task automatic t_coarse();
      wb(1, ADDR_CTRL, 32'h10);
      set_i(0, 900, 0);
      tick(10);
      chk("coarse on", 1, 32'(coarse));
      tick(SLOW + 4);
      chk("coarse pickup", 0, 32'(trip));
      set_i(0, 3000, 0);
      tick(FAST + 9);
      chk("internal", 1, 32'(flt));
      set_i(0, 0, 0);
      tick(12);
      wb(0, ADDR_STATUS, 0);
      chk("external block", 32'h1139, rdat);
      wb(0, ADDR_SAT, 0);
      chk("external", 1, rdat);
      wb(0, ADDR_TRIPS, 0);
      chk("trip count", 1, rdat);
      wb(1, ADDR_TRIPS, 0);
      wb(0, ADDR_TRIPS, 0);
      chk("count clear", 0, rdat);
      tick(3 * CYC + 8);
      chk("coarse off", 0, 32'(coarse));
      ack_press();
      wb(1, ADDR_CTRL, 0);
      $display("test coarse done");
   endtask

   initial begin
      tick(10);
      nrst <= 1'b1;
      tick(2);
      t_reset();
      t_fine();
      t_fast();
      t_bias();
      t_coarse();
      end_sim();
   end
   initial begin
      tick(5000);
      chk("watchdog", 32'h0, 32'h1);
      end_sim();
   end
endmodule
